/* rtl/touch_adc_reference_timing_ctrl.sv */
// Reference and touch timing control registers with interval sequencer
//
// The implementer's own choice: the strobed register port.

// Functional notes
// - Index two always reads all ones; writes there do nothing.
// - Bit 4 chooses external (0) or internal (1) reference; resets to 0.
// - Settle code 0..3 holds off measurement 0, 100, 500, 1000 us.
// - Settle delay only with internal reference and power-down-between set.
// - Bit 1 clear keeps reference on; set powers down between; resets to 1.
// - External mode forces internal reference powered down.
// - Bit 0 selects 1.25 V (0) or 2.50 V (1); resets to 0.
// - Writing 0xBB00 to reset command restores all registers to defaults.
// - Precharge precedes sensing, length from three-bit code.
// - Precharge codes give 20, 84, 276, 340, 1044, 1108, 1300, 1364 us.
// - Sense codes give 32, 96, 544, 608, 2080, 2144, 2592, 2656 us.
module touch_adc_reference_timing_ctrl (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  // Register port
  input  wire logic [2:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [15:0] o_rdata,
  // Measurement sequencing
  input  wire logic        i_start,
  output logic             o_ref_on,
  output logic             o_ref_internal,
  output logic             o_ref_high,
  output logic             o_precharge,
  output logic             o_sense,
  output logic             o_done,
  output logic             o_busy
);

  // Microseconds to cycles, at least one cycle
  function automatic logic [19:0] us_cycles(input int unsigned us);
    int unsigned c;
    c = us * touch_ref_timing_pkg::CYC_PER_US;
    us_cycles = (c == 0) ? 20'h00001 : c[19:0];
  endfunction

  logic [4:0]  refctl_q;
  logic [5:0]  timcfg_q;
  logic [15:0] rstall_q;
  logic [15:0] rdata_q;

  touch_ref_timing_pkg::phase_t phase_q;
  touch_ref_timing_pkg::phase_t phase_d;
  logic [19:0] cnt_q;
  logic [19:0] cnt_d;
  logic        done_q;

  wire wr_ref    = i_wr && (i_addr == touch_ref_timing_pkg::ADDR_REFCTL);
  wire wr_tim    = i_wr && (i_addr == touch_ref_timing_pkg::ADDR_TIMCFG);
  wire wr_rst    = i_wr && (i_addr == touch_ref_timing_pkg::ADDR_RSTALL);
  wire rst_all   = wr_rst && (i_wdata == touch_ref_timing_pkg::RSTALL_CODE);
  wire soft_rst  = i_reset || rst_all;

  wire       ref_int    = refctl_q[touch_ref_timing_pkg::REF_SRC_BIT];
  wire       ref_pd     = refctl_q[touch_ref_timing_pkg::REF_PD_BIT];
  wire [1:0] settle_sel = refctl_q[touch_ref_timing_pkg::SETTLE_LSB +: 2];
  wire [2:0] pre_sel    = timcfg_q[touch_ref_timing_pkg::PRE_LSB +: 3];
  wire [2:0] sense_sel  = timcfg_q[touch_ref_timing_pkg::SENSE_LSB +: 3];

  wire settle_used = ref_int && ref_pd && (settle_sel != 2'b00);
  wire [19:0] settle_len = us_cycles(touch_ref_timing_pkg::SETTLE_US[settle_sel]);
  wire [19:0] pre_len    = us_cycles(touch_ref_timing_pkg::PRE_US[pre_sel]);
  wire [19:0] sense_len  = us_cycles(touch_ref_timing_pkg::SENSE_US[sense_sel]);

  // Register storage
  always_ff @(posedge i_clk) begin
    if (soft_rst) begin
      refctl_q <= touch_ref_timing_pkg::REFCTL_RESET;
      timcfg_q <= touch_ref_timing_pkg::TIMCFG_RESET;
      rstall_q <= touch_ref_timing_pkg::RSTALL_RESET;
    end else begin
      if (wr_ref) begin
        refctl_q <= i_wdata[4:0];
      end
      if (wr_tim) begin
        timcfg_q <= i_wdata[5:0];
      end
      if (wr_rst) begin
        rstall_q <= i_wdata;
      end
    end
  end

  // Read mux
  logic [15:0] rd_mux;
  always_comb begin
    unique case (i_addr)
      touch_ref_timing_pkg::ADDR_RSVD2:  rd_mux = touch_ref_timing_pkg::RSVD2_VALUE;
      touch_ref_timing_pkg::ADDR_REFCTL: rd_mux = {11'h000, refctl_q};
      touch_ref_timing_pkg::ADDR_RSTALL: rd_mux = rstall_q;
      touch_ref_timing_pkg::ADDR_TIMCFG: rd_mux = {10'h000, timcfg_q};
      touch_ref_timing_pkg::ADDR_STATUS: rd_mux = {13'h0000, o_busy, phase_q};
      default:                           rd_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rdata_q <= 16'h0000;
    end else if (i_rd) begin
      rdata_q <= rd_mux;
    end else begin
      rdata_q <= 16'h0000;
    end
  end

  // Interval sequencer: settle, precharge, sense
  always_comb begin
    phase_d = phase_q;
    cnt_d   = cnt_q;
    unique case (phase_q)
      touch_ref_timing_pkg::PH_IDLE: begin
        if (i_start) begin
          if (settle_used) begin
            phase_d = touch_ref_timing_pkg::PH_SETTLE;
            cnt_d   = settle_len - 20'h00001;
          end else begin
            phase_d = touch_ref_timing_pkg::PH_PRECHARGE;
            cnt_d   = pre_len - 20'h00001;
          end
        end
      end
      touch_ref_timing_pkg::PH_SETTLE: begin
        if (cnt_q == 20'h00000) begin
          phase_d = touch_ref_timing_pkg::PH_PRECHARGE;
          cnt_d   = pre_len - 20'h00001;
        end else begin
          cnt_d = cnt_q - 20'h00001;
        end
      end
      touch_ref_timing_pkg::PH_PRECHARGE: begin
        if (cnt_q == 20'h00000) begin
          phase_d = touch_ref_timing_pkg::PH_SENSE;
          cnt_d   = sense_len - 20'h00001;
        end else begin
          cnt_d = cnt_q - 20'h00001;
        end
      end
      touch_ref_timing_pkg::PH_SENSE: begin
        if (cnt_q == 20'h00000) begin
          phase_d = touch_ref_timing_pkg::PH_IDLE;
        end else begin
          cnt_d = cnt_q - 20'h00001;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (soft_rst) begin
      phase_q <= touch_ref_timing_pkg::PH_IDLE;
      cnt_q   <= 20'h00000;
      done_q  <= 1'b0;
    end else begin
      phase_q <= phase_d;
      cnt_q   <= cnt_d;
      done_q  <= (phase_q == touch_ref_timing_pkg::PH_SENSE) && (cnt_q == 20'h00000);
    end
  end

  // Reference power: off with external reference, else on always or only while a measurement runs
  assign o_ref_on       = ref_int && (!ref_pd || (phase_q != touch_ref_timing_pkg::PH_IDLE));
  assign o_ref_internal = ref_int;
  assign o_ref_high     = refctl_q[touch_ref_timing_pkg::REF_LVL_BIT];
  assign o_precharge    = (phase_q == touch_ref_timing_pkg::PH_PRECHARGE);
  assign o_sense        = (phase_q == touch_ref_timing_pkg::PH_SENSE);
  assign o_busy         = (phase_q != touch_ref_timing_pkg::PH_IDLE);
  assign o_done         = done_q;
  assign o_rdata        = rdata_q;

endmodule // touch_adc_reference_timing_ctrl

/* rtl/touch_ref_timing_pkg.sv */
// Package: register map, field layout, reset values and timing constants
package touch_ref_timing_pkg;

  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned CYC_PER_US   = CLK_HZ / 1_000_000;

  // Register indices (byte address equals index on this plain port)
  localparam logic [2:0]  ADDR_RSVD2   = 3'h2;
  localparam logic [2:0]  ADDR_REFCTL  = 3'h3;
  localparam logic [2:0]  ADDR_RSTALL  = 3'h4;
  localparam logic [2:0]  ADDR_TIMCFG  = 3'h5;
  localparam logic [2:0]  ADDR_STATUS  = 3'h6;

  localparam logic [15:0] RSVD2_VALUE  = 16'hFFFF;
  localparam logic [15:0] RSTALL_RESET = 16'hFFFF;
  localparam logic [15:0] RSTALL_CODE  = 16'hBB00;

  // Reference control fields
  localparam int unsigned REF_SRC_BIT  = 4;
  localparam int unsigned SETTLE_LSB   = 2;
  localparam int unsigned REF_PD_BIT   = 1;
  localparam int unsigned REF_LVL_BIT  = 0;
  localparam logic [4:0]  REFCTL_RESET = 5'h02;

  // Touch timing fields
  localparam int unsigned PRE_LSB      = 3;
  localparam int unsigned SENSE_LSB    = 0;
  localparam logic [5:0]  TIMCFG_RESET = 6'h00;

  // Interval tables in microseconds
  localparam int unsigned SETTLE_US [4] = '{0, 100, 500, 1000};
  localparam int unsigned PRE_US    [8] = '{20, 84, 276, 340, 1044, 1108, 1300, 1364};
  localparam int unsigned SENSE_US  [8] = '{32, 96, 544, 608, 2080, 2144, 2592, 2656};

  localparam int unsigned CNT_W        = 20;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_SETTLE,
    PH_PRECHARGE,
    PH_SENSE
  } phase_t;

endpackage

/* test/touch_ref_timing_asserts.sv */
// Checker: port-level properties of the reference and touch timing block
module touch_ref_timing_asserts (
  // Watched ports
  input wire logic        i_clk,
  input wire logic        i_reset,
  input wire logic [2:0]  i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [15:0] o_rdata,
  input wire logic        i_start,
  input wire logic        o_ref_on,
  input wire logic        o_ref_internal,
  input wire logic        o_ref_high,
  input wire logic        o_precharge,
  input wire logic        o_sense,
  input wire logic        o_done,
  input wire logic        o_busy
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  a_rsvd_all_ones: assert property (i_rd && i_addr == 3'h2 |=> o_rdata == 16'hFFFF)
    else $error("reserved slot not all ones");
  a_ref_bits_write: assert property (i_wr && i_addr == 3'h3 |=>
    o_ref_internal == $past(i_wdata[4]) && o_ref_high == $past(i_wdata[0]))
    else $error("reference bits not taken");
  a_ext_ref_off: assert property (!o_ref_internal |-> !o_ref_on)
    else $error("internal reference on in external mode");
  a_reset_all_cmd: assert property (i_wr && i_addr == 3'h4 && i_wdata == 16'hBB00 |=>
    !o_busy && !o_ref_internal && !o_ref_high) else $error("reset code ignored");
  a_timcfg_upper: assert property (i_rd && i_addr == 3'h5 |=> o_rdata[15:6] == 10'h000)
    else $error("config upper bits not zero");
  a_start_busy: assert property (i_start && !o_busy |=> o_busy && !o_sense)
    else $error("start not taken or sense first");
  a_pre_min_len: assert property ($rose(o_precharge) |-> o_precharge [*8])
    else $error("precharge too short");
  a_sense_after_pre: assert property ($rose(o_sense) |-> $past(o_precharge))
    else $error("sense without precharge");
  a_done_ends: assert property ($fell(o_sense) && !$past(i_wr) |-> o_done && !o_busy)
    else $error("done missing after sense");
  c_done: cover property (o_done);
  c_settle: cover property (o_busy && !o_precharge && !o_sense);
  c_rsvd_read: cover property (i_rd && i_addr == 3'h2);
endmodule // touch_ref_timing_asserts

bind touch_adc_reference_timing_ctrl touch_ref_timing_asserts touch_ref_timing_asserts_inst (
  .i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .i_start(i_start), .o_ref_on(o_ref_on),
  .o_ref_internal(o_ref_internal), .o_ref_high(o_ref_high), .o_precharge(o_precharge),
  .o_sense(o_sense), .o_done(o_done), .o_busy(o_busy));

/* test/tb.sv */
// Testbench: register table, interval lengths and reset-all command
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [2:0] a; logic [15:0] d; logic [15:0] e;} row_t;
  logic        i_clk, i_reset, i_wr, i_rd, i_start;
  logic [2:0]  i_addr;
  logic [15:0] i_wdata, o_rdata;
  logic        o_ref_on, o_ref_internal, o_ref_high, o_precharge, o_sense, o_done, o_busy;
  int          n_mismatch = 0;
  int          check_count = 0;
  int          cs, cp, cn;
  row_t        rows [6] = '{'{3'h3, 16'h0013, 16'h0013}, '{3'h3, 16'hFFFF, 16'h001F},
    '{3'h5, 16'h003F, 16'h003F}, '{3'h5, 16'h0000, 16'h0000},
    '{3'h2, 16'h1234, 16'hFFFF}, '{3'h6, 16'hFFFF, 16'h0000}};
  touch_adc_reference_timing_ctrl touch_adc_reference_timing_ctrl_inst (
    .i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_start(i_start), .o_ref_on(o_ref_on),
    .o_ref_internal(o_ref_internal), .o_ref_high(o_ref_high), .o_precharge(o_precharge),
    .o_sense(o_sense), .o_done(o_done), .o_busy(o_busy));
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
      n_mismatch++;
    end
  endtask
  task wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task rd(input logic [2:0] a, input logic [15:0] e);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk("rdata", {16'h0000, e}, {16'h0000, o_rdata});
  endtask
  // One measurement: phase lengths in cycles, reference state while busy
  task run(input logic [31:0] es, input logic [31:0] ep, input logic [31:0] en, input logic on);
    @(posedge i_clk);
    i_start <= 1'b1;
    @(posedge i_clk);
    i_start <= 1'b0;
    cs = 0;
    cp = 0;
    cn = 0;
    #1 chk("ref_on busy", {31'h0, on}, {31'h0, o_ref_on});
    repeat (300000) begin
      if (o_done === 1'b1) break;
      cs += int'(o_busy && !o_precharge && !o_sense);
      cp += int'(o_precharge);
      cn += int'(o_sense);
      @(posedge i_clk);
      #1;
    end
    chk("done", 32'h1, {31'h0, o_done});
    chk("settle", es, cs);
    chk("precharge", ep, cp);
    chk("sense", en, cn);
    $display("measurement test done");
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #1_000_000;
    n_mismatch++;
    wrap_up;
  end
  initial begin
    {i_reset, i_wr, i_rd, i_start, i_addr, i_wdata} = {4'h8, 19'h0};
    repeat (4) @(posedge i_clk);
    i_reset <= 1'b0;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    $display("table test done");
    wr(3'h3, 16'h0016);
    #1 chk("ref_on idle", 32'h0, {31'h0, o_ref_on});
    run(10000, 2000, 3200, 1'b1);
    wr(3'h3, 16'h0014);
    #1 chk("ref_on idle", 32'h1, {31'h0, o_ref_on});
    wr(3'h5, 16'h0009);
    run(0, 8400, 9600, 1'b1);
    wr(3'h3, 16'h0006);
    run(0, 8400, 9600, 1'b0);
    wr(3'h3, 16'h0017);
    run(10000, 8400, 9600, 1'b1);
    @(posedge i_clk);
    i_start <= 1'b1;
    @(posedge i_clk);
    i_start <= 1'b0;
    wr(3'h4, 16'hBB00);
    #1 chk("busy", 32'h0, {31'h0, o_busy});
    rd(3'h3, 16'h0002);
    rd(3'h4, 16'hFFFF);
    rd(3'h5, 16'h0000);
    rd(3'h2, 16'hFFFF);
    $display("reset command test done");
    wrap_up;
  end
endmodule // tb
